// ---- core/opfc_pkg.sv ----
// constants for the output port and flow control block
package opfc_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_SRC_CFG = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_CMD = 8'h08;
   localparam logic [7:0] OFS_LATCH = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   // ----------------------------------------
   // fields
   // ----------------------------------------
   localparam int MODE_CTS_GATE_BIT = 0;
   localparam int MODE_RTS_CTRL_BIT = 1;
   localparam int CMD_CODE_LSB = 8;
   localparam int CMD_CODE_W = 4;
   localparam int ST_TX_ALLOW_BIT = 0;
   localparam int ST_RTS_N_BIT = 1;
   localparam int ST_CTS_N_BIT = 2;
   // ----------------------------------------
   // command codes and reset values
   // ----------------------------------------
   localparam logic [3:0] CMD_SET_BITS = 4'he;
   localparam logic [3:0] CMD_CLR_BITS = 4'hf;
   localparam logic [7:0] RST_SRC_CFG = 8'h00;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [1:0] RST_MODE = 2'h0;
   // ----------------------------------------
   // host bus modes
   // ----------------------------------------
   typedef enum logic {BUS_SPLIT_STROBE, BUS_DATA_STROBE} bus_mode_e;
endpackage

// ---- core/output_port_flow_control.sv ----
// output pin sourcing, rts/cts flow control and host access end detection
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps

// Operation
// - config register picks source of pins 2-7
// - pins 0 and 1 sourced by mode/command
// - latch-driven pins show inverted latch bit
// - command E sets, F clears latch
// - only ones in data word act
// - cts_n on input zero, rts_n on pin zero
// - cts high: finish character, then stop
// - gate disabled: cts pin ignored
// - rts high on full fifo plus start bit
// - split mode: first rising ce/wr/rd ends
// - strobe mode: ce rise or ack fall ends
module output_port_flow_control
   import opfc_pkg::*;
#(
   parameter int PIN_W = 8
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // line side
   input wire logic i_input_pin_zero,
   input wire logic [PIN_W-1:2] i_alt_func,
   output logic [PIN_W-1:0] o_output_pins,
   // transmitter and receiver status
   input wire logic i_tx_busy,
   output logic o_tx_allow,
   input wire logic i_rx_fifo_full,
   input wire logic i_rx_start_bit,
   input wire logic i_rx_fifo_read,
   // host bus pins
   input wire opfc_pkg::bus_mode_e i_bus_mode,
   input wire logic i_chip_enable_n,
   input wire logic i_write_strobe_n,
   input wire logic i_read_strobe_n,
   output logic o_transfer_ack_n,
   output logic o_access_end
);
   import opfc_pkg::*;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [PIN_W-1:0] src_cfg;
   logic [PIN_W-1:0] out_pin_latch;
   logic tx_cts_gate_enable;
   logic rx_rts_control_enable;
   logic request_to_send_n;
   logic wr_go;
   logic rd_go;
   logic [3:0] cmd_code;
   logic [PIN_W-1:0] cmd_mask;
   logic cts_high;
   logic [31:0] next_prdata;
   logic next_slverr;
   logic [PIN_W-1:0] next_pins;
   logic next_tx_allow;

   assign wr_go = i_psel & i_penable & o_pready & i_pwrite;
   assign rd_go = i_psel & i_penable & ~o_pready & ~i_pwrite;
   assign cmd_code = i_pwdata[CMD_CODE_LSB +: CMD_CODE_W];
   assign cmd_mask = i_pwdata[PIN_W-1:0];
   assign cts_high = i_input_pin_zero;

   // ----------------------------------------
   // apb handshake
   // ----------------------------------------
   // one wait state keeps pready and read data on flops
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_pready <= 1'b0;
      end else begin
         o_pready <= i_psel & i_penable & ~o_pready;
      end
   end

   always_comb begin
      next_prdata = 32'h0;
      next_slverr = 1'b0;
      case (i_paddr)
         OFS_SRC_CFG: next_prdata[PIN_W-1:0] = src_cfg;
         OFS_MODE: begin
            next_prdata[MODE_CTS_GATE_BIT] = tx_cts_gate_enable;
            next_prdata[MODE_RTS_CTRL_BIT] = rx_rts_control_enable;
         end
         OFS_CMD: next_prdata = 32'h0;
         OFS_LATCH: next_prdata[PIN_W-1:0] = out_pin_latch;
         OFS_STATUS: begin
            next_prdata[ST_TX_ALLOW_BIT] = o_tx_allow;
            next_prdata[ST_RTS_N_BIT] = request_to_send_n;
            next_prdata[ST_CTS_N_BIT] = i_input_pin_zero;
         end
         default: next_slverr = 1'b1;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_prdata <= 32'h0;
         o_pslverr <= 1'b0;
      end else if (i_psel & i_penable & ~o_pready) begin
         o_prdata <= rd_go ? next_prdata : 32'h0;
         o_pslverr <= next_slverr;
      end else begin
         o_prdata <= 32'h0;
         o_pslverr <= 1'b0;
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         src_cfg <= RST_SRC_CFG;
      end else if (wr_go && i_paddr == OFS_SRC_CFG) begin
         src_cfg <= i_pwdata[PIN_W-1:0];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         {rx_rts_control_enable, tx_cts_gate_enable} <= RST_MODE;
      end else if (wr_go && i_paddr == OFS_MODE) begin
         tx_cts_gate_enable <= i_pwdata[MODE_CTS_GATE_BIT];
         rx_rts_control_enable <= i_pwdata[MODE_RTS_CTRL_BIT];
      end
   end

   // ----------------------------------------
   // output latch commands
   // ----------------------------------------
   // other codes written to the command word are ignored here
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         out_pin_latch <= RST_LATCH;
      end else if (wr_go && i_paddr == OFS_CMD) begin
         if (cmd_code == CMD_SET_BITS) begin
            out_pin_latch <= out_pin_latch | cmd_mask;
         end else if (cmd_code == CMD_CLR_BITS) begin
            out_pin_latch <= out_pin_latch & ~cmd_mask;
         end
      end
   end

   // ----------------------------------------
   // transmitter cts gating
   // ----------------------------------------
   // a character already being shifted is never cut short
   always_comb begin
      if (!tx_cts_gate_enable || !cts_high) begin
         next_tx_allow = 1'b1;
      end else if (i_tx_busy) begin
         next_tx_allow = o_tx_allow;
      end else begin
         next_tx_allow = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_tx_allow <= 1'b1;
      end else begin
         o_tx_allow <= next_tx_allow;
      end
   end

   // ----------------------------------------
   // receiver rts
   // ----------------------------------------
   // the set wins over a read in the same cycle
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         request_to_send_n <= 1'b0;
      end else if (!rx_rts_control_enable) begin
         request_to_send_n <= 1'b0;
      end else if (i_rx_fifo_full && i_rx_start_bit) begin
         request_to_send_n <= 1'b1;
      end else if (i_rx_fifo_read) begin
         request_to_send_n <= 1'b0;
      end
   end

   // ----------------------------------------
   // output pin sources
   // ----------------------------------------
   always_comb begin
      next_pins = ~out_pin_latch;
      if (rx_rts_control_enable) begin
         next_pins[0] = request_to_send_n;
      end
      for (int i = 2; i < PIN_W; i++) begin
         if (src_cfg[i]) begin
            next_pins[i] = i_alt_func[i];
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_output_pins <= ~RST_LATCH;
      end else begin
         o_output_pins <= next_pins;
      end
   end

   // ----------------------------------------
   // host bus access end
   // ----------------------------------------
   logic ce_q;
   logic wr_q;
   logic rd_q;
   logic in_access;
   logic ce_rise;
   logic strobe_rise;
   logic next_end;

   assign ce_rise = ~ce_q & i_chip_enable_n;
   assign strobe_rise = (~wr_q & i_write_strobe_n) | (~rd_q & i_read_strobe_n);

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         ce_q <= 1'b1;
         wr_q <= 1'b1;
         rd_q <= 1'b1;
      end else begin
         ce_q <= i_chip_enable_n;
         wr_q <= i_write_strobe_n;
         rd_q <= i_read_strobe_n;
      end
   end

   // only the first terminating edge of an access counts
   always_comb begin
      next_end = 1'b0;
      if (in_access) begin
         if (i_bus_mode == BUS_SPLIT_STROBE) begin
            next_end = ce_rise | strobe_rise;
         end else begin
            next_end = ce_rise | ~o_transfer_ack_n;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         in_access <= 1'b0;
      end else if (next_end) begin
         in_access <= 1'b0;
      end else if (!i_chip_enable_n && ce_q) begin
         in_access <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_access_end <= 1'b0;
      end else begin
         o_access_end <= next_end;
      end
   end

   // ack falls one cycle into a data-strobe access, held until ce rises
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_transfer_ack_n <= 1'b1;
      end else if (i_chip_enable_n || i_bus_mode != BUS_DATA_STROBE) begin
         o_transfer_ack_n <= 1'b1;
      end else if (in_access) begin
         o_transfer_ack_n <= 1'b0;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_CFG_SRC: assert property (@(posedge i_core_clk) disable iff (i_reset)
      src_cfg[2] |=> o_output_pins[2] == $past(i_alt_func[2]))
      else $error("pin two does not follow alternate source");

   AST_PIN1_LATCH: assert property (@(posedge i_core_clk) disable iff (i_reset)
      1'b1 |=> o_output_pins[1] == ~$past(out_pin_latch[1]))
      else $error("pin one not driven from latch");

   AST_LATCH_INV: assert property (@(posedge i_core_clk) disable iff (i_reset)
      !src_cfg[5] |=> o_output_pins[5] == ~$past(out_pin_latch[5]))
      else $error("latch pin not inverted");

   AST_CMD_SET: assert property (@(posedge i_core_clk) disable iff (i_reset)
      wr_go && i_paddr == OFS_CMD && cmd_code == CMD_SET_BITS
      |=> out_pin_latch == ($past(out_pin_latch) | $past(cmd_mask)))
      else $error("set command wrong");

   AST_CMD_CLR: assert property (@(posedge i_core_clk) disable iff (i_reset)
      wr_go && i_paddr == OFS_CMD && cmd_code == CMD_CLR_BITS
      |=> out_pin_latch == ($past(out_pin_latch) & ~$past(cmd_mask)))
      else $error("clear command wrong");

   AST_RTS_PIN: assert property (@(posedge i_core_clk) disable iff (i_reset)
      rx_rts_control_enable |=> o_output_pins[0] == $past(request_to_send_n))
      else $error("rts not on pin zero");

   AST_TX_FINISH: assert property (@(posedge i_core_clk) disable iff (i_reset)
      o_tx_allow && i_tx_busy ##1 i_tx_busy |-> o_tx_allow)
      else $error("character cut short");

   AST_TX_STOP: assert property (@(posedge i_core_clk) disable iff (i_reset)
      tx_cts_gate_enable && cts_high && !i_tx_busy |=> !o_tx_allow)
      else $error("transmitter not stopped");

   AST_CTS_IGNORED: assert property (@(posedge i_core_clk) disable iff (i_reset)
      !tx_cts_gate_enable |=> o_tx_allow)
      else $error("cts acted while disabled");

   AST_RTS_HIGH: assert property (@(posedge i_core_clk) disable iff (i_reset)
      rx_rts_control_enable && i_rx_fifo_full && i_rx_start_bit |=> ##1 o_output_pins[0])
      else $error("rts not raised");

   AST_RTS_LOW: assert property (@(posedge i_core_clk) disable iff (i_reset)
      rx_rts_control_enable && request_to_send_n && i_rx_fifo_read && !i_rx_start_bit
      |=> !request_to_send_n)
      else $error("rts not released");

   AST_SPLIT_END: assert property (@(posedge i_core_clk) disable iff (i_reset)
      in_access && i_bus_mode == BUS_SPLIT_STROBE && (ce_rise || strobe_rise)
      |=> o_access_end && !in_access)
      else $error("split access not ended");

   AST_DS_END: assert property (@(posedge i_core_clk) disable iff (i_reset)
      in_access && i_bus_mode == BUS_DATA_STROBE && !i_chip_enable_n
      |-> ##[0:2] (o_access_end || i_chip_enable_n))
      else $error("strobe access not ended");

   COV_SET_CMD: cover property (@(posedge i_core_clk) disable iff (i_reset)
      wr_go && i_paddr == OFS_CMD && cmd_code == CMD_SET_BITS);
   COV_TX_STOP: cover property (@(posedge i_core_clk) disable iff (i_reset)
      o_tx_allow ##1 !o_tx_allow);
   COV_RTS_CYCLE: cover property (@(posedge i_core_clk) disable iff (i_reset)
      request_to_send_n ##[1:20] !request_to_send_n);
   COV_DS_ACCESS: cover property (@(posedge i_core_clk) disable iff (i_reset)
      !o_transfer_ack_n ##1 o_access_end);

endmodule // output_port_flow_control

// ---- test/remote_serial_end.sv ----
// remote serial end model facing the rts/cts pins
`timescale 1ns/1ps
module remote_serial_end (
   // clock
   input wire logic i_core_clk,
   // bench commands
   input wire logic i_hold_off,
   input wire logic i_send,
   // line side
   input wire logic i_request_to_send_n,
   output logic o_clear_to_send_n,
   output logic o_start_bit
);
   // remote receiver keeps cts low while it can take data
   assign o_clear_to_send_n = i_hold_off;
   // a polite remote transmitter starts no character while rts is high
   always_ff @(posedge i_core_clk) begin
      o_start_bit <= i_send & ~i_request_to_send_n;
   end
endmodule // remote_serial_end

// ---- test/output_port_flow_control_tb.sv ----
// testbench for output pin sourcing, flow control and host access ends
`timescale 1ns/1ps
module output_port_flow_control_tb;
   import opfc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic pready, pslverr, tx_allow, ack_n, acc_end, cts_n, start;
   logic [31:0] prdata;
   logic [7:0] pins;
   logic [7:2] alt = 6'b101010;
   logic busy = 1'b0, full = 1'b0, fread = 1'b0, hold = 1'b0, send = 1'b0;
   logic ce_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
   bus_mode_e mode = BUS_SPLIT_STROBE;
   int n_errors = 0, cmp_count = 0, cyc = 0, ends = 0;
   always #5 clk = ~clk;
   output_port_flow_control uut (.i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
      .o_pslverr(pslverr), .i_input_pin_zero(cts_n), .i_alt_func(alt), .o_output_pins(pins),
      .i_tx_busy(busy), .o_tx_allow(tx_allow), .i_rx_fifo_full(full), .i_rx_start_bit(start),
      .i_rx_fifo_read(fread), .i_bus_mode(mode), .i_chip_enable_n(ce_n), .i_write_strobe_n(wr_n),
      .i_read_strobe_n(rd_n), .o_transfer_ack_n(ack_n), .o_access_end(acc_end));
   remote_serial_end far_end (.i_core_clk(clk), .i_hold_off(hold), .i_send(send),
      .i_request_to_send_n(pins[0]), .o_clear_to_send_n(cts_n), .o_start_bit(start));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // bit 31 of the returned word carries pslverr; registers never use it
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no local limit: a slave that never answers is caught by the cycle ceiling
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = {pslverr, prdata[30:0]};
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      check(name, r, exp);
   endtask
   task automatic pin_chk(input string name, input logic [7:0] exp);
      repeat (3) @(posedge clk);
      check(name, {24'h0, pins}, {24'h0, exp});
   endtask
   always @(posedge clk) begin
      cyc++;
      if (acc_end === 1'b1) ends++;
      if (cyc == 3000) begin
         n_errors++;
         finish_test();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("tx_allow_rst", tx_allow, 1'b1);
      pin_chk("pins_rst", 8'hff);
      rd_chk("latch_rst", OFS_LATCH, 32'h0);
      wr(OFS_CMD, {20'h0, CMD_SET_BITS, 8'ha5});
      rd_chk("latch_set", OFS_LATCH, 32'ha5);
      wr(OFS_CMD, {20'h0, CMD_CLR_BITS, 8'h21});
      rd_chk("latch_clr", OFS_LATCH, 32'h84);
      pin_chk("pins_latch", 8'h7b);
      wr(OFS_SRC_CFG, 32'hff);
      pin_chk("pins_alt_all", {alt, 2'b11});
      wr(OFS_SRC_CFG, 32'h3c);
      pin_chk("pins_alt_mix", {2'b01, alt[5:2], 2'b11});
      rd_chk("unmapped", 8'h14, 32'h80000000);
      // cts gating: the character in flight finishes first
      wr(OFS_MODE, 32'h1);
      busy <= 1'b1;
      hold <= 1'b1;
      repeat (4) @(posedge clk);
      check("tx_allow_busy", tx_allow, 1'b1);
      busy <= 1'b0;
      repeat (3) @(posedge clk);
      check("tx_allow_stop", tx_allow, 1'b0);
      rd_chk("status_cts", OFS_STATUS, 32'h4);
      wr(OFS_MODE, 32'h0);
      repeat (3) @(posedge clk);
      check("tx_allow_nogate", tx_allow, 1'b1);
      hold <= 1'b0;
      // rts: latch bit zero is clear, so pin zero differs between sources
      // pins 2-5 still follow the alternate inputs from the mixed source setting
      wr(OFS_MODE, 32'h2);
      full <= 1'b1;
      pin_chk("rts_full_only", {2'b01, alt[5:2], 2'b10});
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      pin_chk("rts_start", {2'b01, alt[5:2], 2'b11});
      fread <= 1'b1;
      @(posedge clk);
      fread <= 1'b0;
      full <= 1'b0;
      pin_chk("rts_freed", {2'b01, alt[5:2], 2'b10});
      // host bus: a later ce rise must not end the access twice
      // wr_n is left high for the whole of every ce low window
      for (int m = 0; m < 2; m++) begin
         mode <= bus_mode_e'(m);
         @(posedge clk);
         ce_n <= 1'b0;
         rd_n <= (m == 0) ? 1'b0 : 1'b1;
         repeat (3) @(posedge clk);
         rd_n <= 1'b1;
         repeat (3) @(posedge clk);
         check("access_end_first", ends, m + 1);
         if (m == 1) check("ack_low", ack_n, 1'b0);
         ce_n <= 1'b1;
         repeat (3) @(posedge clk);
         check("access_end_once", ends, m + 1);
         check("ack_idle", ack_n, 1'b1);
      end
      finish_test();
   end
endmodule // output_port_flow_control_tb
